// file: hdl/lpc_pkg.sv
// shared constants and types for the lamp pulse controller
package lpc_pkg;
  localparam int NCH = 8;
  localparam int NTM = 4;
  localparam int CW = 20;
  localparam int DIVW = 18;
  localparam int RESW = 5;
  localparam int DUTYW = 25;
  localparam int STEPW = 10;
  localparam int AW = 9;
  // word indexes of the register map
  localparam logic [6:0] TMR_BASE = 7'h00;
  localparam logic [6:0] CH_BASE = 7'h10;
  localparam logic [6:0] GLB_IDX = 7'h50;
  // timer config fields
  localparam int TC_DIV_LSB = 0;
  localparam int TC_RES_LSB = 18;
  localparam int TC_SRC_BIT = 23;
  localparam int TC_PAUSE_BIT = 24;
  localparam int TC_CLR_BIT = 25;
  localparam int TC_UPD_BIT = 26;
  localparam logic [24:0] TC_RST_VAL = 25'h0080100;
  // channel high point / timer select fields
  localparam int HP_TSEL_LSB = 20;
  localparam logic [21:0] HP_RST_VAL = 22'h000000;
  // fade config fields
  localparam int FD_CYC_LSB = 0;
  localparam int FD_NUM_LSB = 10;
  localparam int FD_SCL_LSB = 20;
  localparam int FD_INC_BIT = 30;
  localparam int FD_START_BIT = 31;
  localparam logic [30:0] FD_RST_VAL = 31'h00000000;
  localparam logic [3:0] LFSR_SEED = 4'h1;
  typedef enum logic [0:0] {
    FADE_IDLE = 1'b0,
    FADE_RUN = 1'b1
  } lpc_fade_type;
endpackage : lpc_pkg

// file: hdl/lpc_grp_if.sv
// time bases of one timer group, shared by its channels
`timescale 1ns/10ps
interface lpc_grp_if;
  logic [19:0] cnt [4];
  logic [3:0] wrap;
  modport src (output cnt, output wrap);
  modport snk (input cnt, input wrap);
endinterface : lpc_grp_if

// file: hdl/lpc_timer.sv
// one timer: fractional divider plus resolution-limited counter
`timescale 1ns/10ps
module lpc_timer #(
  parameter int IDX = 0,
  parameter bit SLOW = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic [lpc_pkg::DIVW-1:0] div_i,
  input wire logic [lpc_pkg::RESW-1:0] res_i,
  input wire logic pause_i,
  input wire logic clr_i,
  input wire logic upd_i,
  lpc_grp_if.src g
);
  import lpc_pkg::*;
  logic [DIVW-1:0] div_q, div_d;
  logic [RESW-1:0] res_q, res_d;
  logic [9:0] dcnt_q, dcnt_d;
  logic [7:0] acc_q, acc_d;
  logic ext_q, ext_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic wrap_q, wrap_d;
  logic dout;
  logic [CW-1:0] top;
  logic [8:0] sum;

  // divider, counter and shadow loading
  always_comb begin
    div_d = div_q;
    res_d = res_q;
    dcnt_d = dcnt_q;
    acc_d = acc_q;
    ext_d = ext_q;
    cnt_d = cnt_q;
    wrap_d = 1'b0;
    top = (res_q >= 5'd20) ? 20'hFFFFF : 20'((21'h1 << res_q) - 21'h1);
    sum = {1'b0, acc_q} + {1'b0, div_q[7:0]};
    // period is A, or A+1 when the fraction accumulator carries
    dout = tick_i && ({1'b0, dcnt_q} + 11'h1 >= {1'b0, div_q[17:8]} + {10'h0, ext_q});
    if (tick_i) begin
      dcnt_d = dout ? 10'h0 : dcnt_q + 10'h1;
    end
    if (dout) begin
      acc_d = sum[7:0];
      ext_d = sum[8];
    end
    if (dout && !pause_i) begin
      // at or above the top: a slow range shrunk below the count still wraps at once
      if (cnt_q >= top) begin
        cnt_d = '0;
        wrap_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 20'h1;
      end
    end
    if (clr_i) begin
      cnt_d = '0;
      dcnt_d = '0;
    end
    // fast shadows only move at the wrap or a clear so a period is never cut short
    if ((!SLOW && (wrap_d || clr_i)) || (SLOW && upd_i)) begin
      div_d = div_i;
      res_d = res_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      div_q <= TC_RST_VAL[TC_DIV_LSB +: DIVW];
      res_q <= TC_RST_VAL[TC_RES_LSB +: RESW];
      dcnt_q <= '0;
      acc_q <= '0;
      ext_q <= 1'b0;
      cnt_q <= '0;
      wrap_q <= 1'b0;
    end else begin
      div_q <= div_d;
      res_q <= res_d;
      dcnt_q <= dcnt_d;
      acc_q <= acc_d;
      ext_q <= ext_d;
      cnt_q <= cnt_d;
      wrap_q <= wrap_d;
    end
  end

  assign g.cnt[IDX] = cnt_q;
  assign g.wrap[IDX] = wrap_q;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_wrap_zero: assert property (wrap_q |-> cnt_q == '0)
    else $error("wrap without counter restart");
  a_pause_hold: assert property (pause_i && !clr_i |=> $stable(cnt_q))
    else $error("counter moved while paused");
  a_fast_shadow: assert property (!SLOW && !wrap_d && !clr_i |=> $stable(div_q))
    else $error("fast divider changed outside wrap");
  a_slow_update: assert property (SLOW && upd_i |=> res_q == $past(res_i))
    else $error("slow resolution not applied");
endmodule : lpc_timer

// file: hdl/lpc_chan.sv
// one pwm channel: compare, dither and automatic fade
`timescale 1ns/10ps
module lpc_chan (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  lpc_grp_if.snk g,
  input wire logic [1:0] tsel_i,
  input wire logic [19:0] hp_i,
  input wire logic duty_ld_i,
  input wire logic [lpc_pkg::DUTYW-1:0] duty_i,
  input wire logic [3:0] rnd_i,
  input wire logic start_i,
  input wire logic inc_i,
  input wire logic [lpc_pkg::STEPW-1:0] cyc_i,
  input wire logic [lpc_pkg::STEPW-1:0] num_i,
  input wire logic [lpc_pkg::STEPW-1:0] scl_i,
  output logic pwm_o,
  output logic done_o,
  output logic [lpc_pkg::DUTYW-1:0] duty_o
);
  import lpc_pkg::*;
  lpc_fade_type st_q, st_d;
  logic [DUTYW-1:0] duty_q, duty_d;
  logic [STEPW-1:0] cyc_q, cyc_d, stp_q, stp_d;
  logic pwm_q, pwm_d, ext_q, ext_d, done_q, done_d;
  logic [19:0] cnt, lowpt;
  logic wrap;

  always_comb begin
    cnt = g.cnt[tsel_i];
    wrap = g.wrap[tsel_i];
    lowpt = hp_i + duty_q[23:4] + {19'h0, ext_q};
    st_d = st_q;
    duty_d = duty_q;
    cyc_d = cyc_q;
    stp_d = stp_q;
    done_d = 1'b0;
    pwm_d = pwm_q;
    ext_d = ext_q;
    // one dither draw per period keeps each pulse a whole length
    if (wrap) begin
      ext_d = (duty_q[3:0] != 4'h0) && (duty_q[3:0] >= rnd_i);
    end
    if (cnt == hp_i) begin
      pwm_d = 1'b1;
    end
    if (cnt == lowpt) begin
      pwm_d = 1'b0;
    end
    if (duty_ld_i) begin
      duty_d = duty_i;
    end
    case (st_q)
      FADE_IDLE: begin
        if (start_i) begin
          st_d = FADE_RUN;
          cyc_d = '0;
          stp_d = '0;
        end
      end
      FADE_RUN: begin
        if (num_i == '0) begin
          st_d = FADE_IDLE;
          done_d = 1'b1;
        end else if (wrap) begin
          if (cyc_q >= cyc_i) begin
            cyc_d = '0;
            duty_d[24:4] = inc_i ? duty_q[24:4] + {11'h0, scl_i} : duty_q[24:4] - {11'h0, scl_i};
            stp_d = stp_q + 10'h1;
            if (stp_q + 10'h1 >= num_i) begin
              st_d = FADE_IDLE;
              done_d = 1'b1;
            end
          end else begin
            cyc_d = cyc_q + 10'h1;
          end
        end
      end
      default: st_d = FADE_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_q <= FADE_IDLE;
      duty_q <= '0;
      cyc_q <= '0;
      stp_q <= '0;
      pwm_q <= 1'b0;
      ext_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      duty_q <= duty_d;
      cyc_q <= cyc_d;
      stp_q <= stp_d;
      pwm_q <= pwm_d;
      ext_q <= ext_d;
      done_q <= done_d;
    end
  end

  assign pwm_o = pwm_q;
  assign done_o = done_q;
  assign duty_o = duty_q;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_begin;
    st_q == FADE_IDLE && start_i;
  endsequence
  a_fade_begin: assert property (s_begin |=> st_q == FADE_RUN)
    else $error("fade did not start");
  a_high_set: assert property (cnt == hp_i && cnt != lowpt |=> pwm_q)
    else $error("output not raised at high point");
  a_low_set: assert property (cnt == lowpt |=> !pwm_q)
    else $error("output not dropped at low point");
  a_done_idle: assert property (done_q |-> st_q == FADE_IDLE && !$past(done_q))
    else $error("done pulse without fade end");
  a_step_dir: assert property (st_q == FADE_RUN && wrap && cyc_q >= cyc_i && num_i != '0
      && !duty_ld_i && inc_i |=> duty_q[24:4] == $past(duty_q[24:4]) + $past(scl_i))
    else $error("fade step wrong");
endmodule : lpc_chan

// file: hdl/lpc_top.sv
// lamp pulse controller top: registers, timers and channels
`timescale 1ns/10ps
// What this block does
// - sixteen channels, eight fast eight slow
// - channel picks one of four group timers
// - fast timer source: reference tick or bus
// - divider is ten-bit integer, eight-bit fraction
// - fraction spreads longer periods evenly
// - counter wraps at resolution maximum, overflow event
// - software clears, pauses and reads counter
// - timer gives twenty-bit value to channels
// - slow clock is bus or eight-megahertz tick
// - fast settings change only at wrap or clear
// - slow settings change on update bit
// - output high when count equals high point
// - output low at high point plus duty
// - fractional duty lengthens pulses by chance
// - start bit begins fade, direction bit chooses
// - each step interval adds or subtracts step
// - fade ends after configured step count
// - finished fade pulses its done event
// - each timer pulses its own overflow event
module lpc_top (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ref_tick_i,
  input wire logic slow8_tick_i,
  input wire logic [lpc_pkg::AW-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic [15:0] pwm_o,
  output logic [7:0] fast_fade_done_irq_o,
  output logic [7:0] slow_fade_done_irq_o,
  output logic [3:0] fast_timer_wrap_irq_o,
  output logic [3:0] slow_timer_wrap_irq_o
);
  import lpc_pkg::*;

  logic [24:0] tcfg_q [8];
  logic [24:0] tcfg_d [8];
  logic [21:0] hp_q [16];
  logic [21:0] hp_d [16];
  logic [30:0] fd_q [16];
  logic [30:0] fd_d [16];
  logic slow_sel_q, slow_sel_d;
  logic [3:0] rnd_q, rnd_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] tclr, tupd, ttick;
  logic [15:0] dld, fst, done;
  logic [19:0] tval [8];
  logic [DUTYW-1:0] cdu [16];
  logic [6:0] idx;

  lpc_grp_if gif[2] ();

  assign idx = addr_i[8:2];

  // free-running dither source, x^4+x^3+1, never reaches zero
  always_comb begin
    rnd_d = {rnd_q[2:0], rnd_q[3] ^ rnd_q[2]};
  end

  // register writes; clear, update and start bits act once, never stored
  always_comb begin
    slow_sel_d = slow_sel_q;
    tclr = '0;
    tupd = '0;
    dld = '0;
    fst = '0;
    for (int t = 0; t < 8; t++) begin
      tcfg_d[t] = tcfg_q[t];
      if (wr_i && idx == 7'(TMR_BASE + 2 * t)) begin
        tcfg_d[t] = wdata_i[24:0];
        tclr[t] = wdata_i[TC_CLR_BIT];
        tupd[t] = wdata_i[TC_UPD_BIT];
      end
    end
    for (int c = 0; c < 16; c++) begin
      hp_d[c] = hp_q[c];
      fd_d[c] = fd_q[c];
      if (wr_i && idx == 7'(CH_BASE + 4 * c)) begin
        hp_d[c] = wdata_i[21:0];
      end
      if (wr_i && idx == 7'(CH_BASE + 4 * c + 1)) begin
        dld[c] = 1'b1;
      end
      if (wr_i && idx == 7'(CH_BASE + 4 * c + 2)) begin
        fd_d[c] = wdata_i[30:0];
        fst[c] = wdata_i[FD_START_BIT];
      end
    end
    if (wr_i && idx == GLB_IDX) begin
      slow_sel_d = wdata_i[0];
    end
  end

  // read data stand in the cycle after the strobe only
  always_comb begin
    rdata_d = 32'h00000000;
    if (rd_i) begin
      for (int t = 0; t < 8; t++) begin
        if (idx == 7'(TMR_BASE + 2 * t)) begin
          rdata_d = {7'h00, tcfg_q[t]};
        end
        if (idx == 7'(TMR_BASE + 2 * t + 1)) begin
          rdata_d = {12'h000, tval[t]};
        end
      end
      for (int c = 0; c < 16; c++) begin
        if (idx == 7'(CH_BASE + 4 * c)) begin
          rdata_d = {10'h000, hp_q[c]};
        end
        if (idx == 7'(CH_BASE + 4 * c + 1)) begin
          rdata_d = {7'h00, cdu[c]};
        end
        if (idx == 7'(CH_BASE + 4 * c + 2)) begin
          rdata_d = {1'b0, fd_q[c]};
        end
      end
      if (idx == GLB_IDX) begin
        rdata_d = {31'h00000000, slow_sel_q};
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      for (int t = 0; t < 8; t++) begin
        tcfg_q[t] <= TC_RST_VAL;
      end
      for (int c = 0; c < 16; c++) begin
        hp_q[c] <= HP_RST_VAL;
        fd_q[c] <= FD_RST_VAL;
      end
      slow_sel_q <= 1'b0;
      rnd_q <= LFSR_SEED;
      rdata_q <= 32'h00000000;
    end else begin
      for (int t = 0; t < 8; t++) begin
        tcfg_q[t] <= tcfg_d[t];
      end
      for (int c = 0; c < 16; c++) begin
        hp_q[c] <= hp_d[c];
        fd_q[c] <= fd_d[c];
      end
      slow_sel_q <= slow_sel_d;
      rnd_q <= rnd_d;
      rdata_q <= rdata_d;
    end
  end

  // four fast then four slow timers
  for (genvar t = 0; t < 8; t++) begin : g_tmr
    if (t < 4) begin : g_fast
      // fast source: bus clock every cycle or the reference tick
      assign ttick[t] = tcfg_q[t][TC_SRC_BIT] ? 1'b1 : ref_tick_i;
    end else begin : g_slow
      // slow source: shared slow clock or the reference tick
      assign ttick[t] = tcfg_q[t][TC_SRC_BIT] ? (slow_sel_q | slow8_tick_i) : ref_tick_i;
    end
    lpc_timer #(
      .IDX(t % 4),
      .SLOW(t >= 4)
    ) u_tmr (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .tick_i(ttick[t]),
      // shadows see the word being written, so values sent with clear or update count
      .div_i(tcfg_d[t][TC_DIV_LSB +: DIVW]),
      .res_i(tcfg_d[t][TC_RES_LSB +: RESW]),
      .pause_i(tcfg_q[t][TC_PAUSE_BIT]),
      .clr_i(tclr[t]),
      .upd_i(tupd[t]),
      .g(gif[t / 4])
    );
    assign tval[t] = gif[t / 4].cnt[t % 4];
  end

  // eight fast then eight slow channels
  for (genvar c = 0; c < 16; c++) begin : g_ch
    lpc_chan u_ch (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .g(gif[c / 8]),
      .tsel_i(hp_q[c][HP_TSEL_LSB +: 2]),
      .hp_i(hp_q[c][19:0]),
      .duty_ld_i(dld[c]),
      .duty_i(wdata_i[DUTYW-1:0]),
      .rnd_i(rnd_q),
      .start_i(fst[c]),
      .inc_i(fd_q[c][FD_INC_BIT]),
      .cyc_i(fd_q[c][FD_CYC_LSB +: STEPW]),
      .num_i(fd_q[c][FD_NUM_LSB +: STEPW]),
      .scl_i(fd_q[c][FD_SCL_LSB +: STEPW]),
      .pwm_o(pwm_o[c]),
      .done_o(done[c]),
      .duty_o(cdu[c])
    );
  end

  assign rdata_o = rdata_q;
  assign fast_fade_done_irq_o = done[7:0];
  assign slow_fade_done_irq_o = done[15:8];
  assign fast_timer_wrap_irq_o = gif[0].wrap;
  assign slow_timer_wrap_irq_o = gif[1].wrap;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_lfsr_live: assert property ($past(rstn_i) |-> rnd_q != 4'h0 && rnd_q != $past(rnd_q))
    else $error("dither source stuck");
  a_read_once: assert property (!rd_i |=> rdata_q == 32'h00000000)
    else $error("read data outside read cycle");
  a_clear_pulse: assert property (tclr[0] |=> tval[0] == 20'h00000)
    else $error("timer clear ignored");
endmodule : lpc_top

// file: bench/lpc_load_model.sv
// load model on one pwm output: measures high time and period
`timescale 1ns/10ps
module lpc_load_model (
  input wire logic sys_clk_i,
  input wire logic pwm_i,
  output logic [15:0] hi_o,
  output logic [15:0] per_o
);
  logic prev_q = 1'b0;
  logic [15:0] pcnt_q = 16'h0000;
  logic [15:0] hcnt_q = 16'h0000;
  logic [15:0] hi_q = 16'h0000;
  logic [15:0] per_q = 16'h0000;
  assign hi_o = hi_q;
  assign per_o = per_q;
  // a load only sees levels; figures refresh at each rising edge of the drive
  always @(posedge sys_clk_i) begin
    prev_q <= pwm_i;
    if (pwm_i && !prev_q) begin
      per_q <= pcnt_q;
      hi_q <= hcnt_q;
      pcnt_q <= 16'h0001;
      hcnt_q <= 16'h0001;
    end else begin
      pcnt_q <= pcnt_q + 16'h0001;
      hcnt_q <= hcnt_q + {15'h0000, pwm_i};
    end
  end
endmodule : lpc_load_model

// file: bench/tb_lpc_top.sv
// self-checking bench for the lamp pulse controller top
`timescale 1ns/10ps
module tb_lpc_top;
  import lpc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ref_tick_i = 1'b0;
  logic slow8_tick_i = 1'b0;
  logic [AW-1:0] addr_i = '0;
  logic [31:0] wdata_i = 32'h00000000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [15:0] pwm_o;
  logic [7:0] ffd;
  logic [7:0] sfd;
  logic [3:0] fwr;
  logic [3:0] swr;
  logic [7:0] wraps;
  logic [15:0] hi;
  logic [15:0] per;
  logic [1:0] rcnt = 2'h0;
  logic [3:0] scnt = 4'h0;
  int mismatches = 0;
  int checks = 0;
  int f;
  int g;
  int n;
  assign wraps = {swr, fwr};
  always #5 sys_clk_i = ~sys_clk_i;
  // reference tick every 4 cycles, slow tick every 10
  always @(posedge sys_clk_i) begin
    rcnt <= rcnt + 2'h1;
    ref_tick_i <= (rcnt == 2'h3);
    scnt <= (scnt == 4'h9) ? 4'h0 : scnt + 4'h1;
    slow8_tick_i <= (scnt == 4'h9);
  end
  lpc_top dut_u (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ref_tick_i(ref_tick_i),
    .slow8_tick_i(slow8_tick_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pwm_o(pwm_o), .fast_fade_done_irq_o(ffd),
    .slow_fade_done_irq_o(sfd), .fast_timer_wrap_irq_o(fwr), .slow_timer_wrap_irq_o(swr)
  );
  lpc_load_model load_u (.sys_clk_i(sys_clk_i), .pwm_i(pwm_o[0]), .hi_o(hi), .per_o(per));
  task automatic bus_wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : bus_wr
  // read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [AW-1:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : bus_rd
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp, input string name);
    logic [31:0] d;
    bus_rd(a, d);
    chk(name, exp, d);
  endtask : rd_chk
  // cycles to the first wrap pulse, then cycles spanning cnt further wraps
  task automatic wrap_span(input int b, input int cnt, output int first, output int span);
    first = 0;
    span = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      first++;
    end while (wraps[b] !== 1'b1 && first < 3000);
    for (int k = 0; k < cnt; k++) begin
      do begin
        @(posedge sys_clk_i);
        #1;
        span++;
      end while (wraps[b] !== 1'b1 && span < 3000);
    end
  endtask : wrap_span
  task automatic wait_fade();
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end while (ffd[0] !== 1'b1 && n < 500);
    chk("fade done pulse", 1, {31'h0, ffd[0]});
  endtask : wait_fade
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // watchdog at 20000 cycles, well beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rd_chk(9'h000, {7'h00, TC_RST_VAL}, "timer config reset");
    bus_wr(9'h1FC, 32'hFFFFFFFF);
    rd_chk(9'h1FC, 32'h00000000, "unmapped word");
    // bus clock, divide by 1, resolution 2, cleared at once
    bus_wr(9'h000, 32'h02880100);
    wrap_span(0, 1, f, g);
    chk("fast wrap period", 4, g);
    bus_wr(9'h000, 32'h008C0100);
    wrap_span(0, 1, f, g);
    chk("old range until wrap", 1, {31'h0, f <= 4});
    chk("new range period", 8, g);
    // divide by 2.5 over 256 divided clocks, two per wrap
    bus_wr(9'h000, 32'h02840280);
    wrap_span(0, 128, f, g);
    chk("fractional span", 640, g);
    // clear while paused, then resume
    bus_wr(9'h000, 32'h03840280);
    repeat (10) @(posedge sys_clk_i);
    rd_chk(9'h004, 32'h00000000, "paused cleared count");
    bus_wr(9'h000, 32'h00840280);
    // running again: each wrap spans one 2-cycle and one 3-cycle divided period
    wrap_span(0, 1, f, g);
    chk("count resumes", 5, g);
    // period 8, high point 1, duty 2
    bus_wr(9'h000, 32'h028C0100);
    bus_wr(9'h040, 32'h00000001);
    bus_wr(9'h044, 32'h00000020);
    repeat (30) @(posedge sys_clk_i);
    chk("pwm period", 8, {16'h0, per});
    chk("pwm high time", 2, {16'h0, hi});
    // rising fade: three steps of one
    bus_wr(9'h048, 32'hC0100C00);
    wait_fade();
    rd_chk(9'h044, 32'h00000050, "duty after rise");
    repeat (40) @(posedge sys_clk_i);
    rd_chk(9'h044, 32'h00000050, "duty holds");
    // falling fade started only after done; two steps of two
    bus_wr(9'h048, 32'h80200800);
    wait_fade();
    rd_chk(9'h044, 32'h00000010, "duty after fall");
    repeat (30) @(posedge sys_clk_i);
    chk("faded high time", 1, {16'h0, hi});
    // half-step fraction: some pulses one count longer, never all or none
    bus_wr(9'h044, 32'h00000028);
    n = 0;
    repeat (15) begin
      wrap_span(0, 1, f, g);
      n += (hi == 16'h0003);
    end
    chk("dithered pulses", 1, {31'h0, n > 0 && n < 15});
    // slow timer: bus clock chosen, range held until update
    bus_wr(9'h140, 32'h00000001);
    bus_wr(9'h020, 32'h00840100);
    n = 0;
    repeat (20) begin
      @(posedge sys_clk_i);
      #1;
      n += swr[0];
    end
    // reset range of two bits, stepped every cycle: one wrap per 4 cycles
    chk("slow range held", 5, n);
    bus_wr(9'h020, 32'h04840100);
    wrap_span(4, 1, f, g);
    chk("slow wrap period", 2, g);
    finish_test();
  end
endmodule : tb_lpc_top
